// ---- src/irq_bank_params.svh ----
`ifndef IRQ_BANK_PARAMS_SVH
`define IRQ_BANK_PARAMS_SVH

// register byte offsets on the apb word map
`define OFF_ENABLE_1     8'h00
`define OFF_ENABLE_2     8'h04
`define OFF_REQUEST_1    8'h08
`define OFF_CORE_CTRL    8'h0C
`define OFF_IRQ_STATUS   8'h10
`define OFF_IRQ_MASK     8'h14
`define OFF_PENDING      8'h18

// implemented / writable bit masks
`define ENABLE_1_MASK    8'h7F
`define ENABLE_2_MASK    8'hFD
`define REQUEST_1_RW     8'h4F
`define REQUEST_1_LEVEL  8'h30
`define REQUEST_2_MASK   8'hFD
`define CORE_CTRL_MASK   8'hC0
`define IRQ_STATUS_MASK  8'h07

// field positions
`define BIT_ADC          6
`define BIT_UART_RX      5
`define BIT_UART_TX      4
`define BIT_SYNC_PORT    3
`define BIT_CAPCMP_ONE   2
`define BIT_TIMER_TWO    1
`define BIT_TIMER_ONE    0
`define BIT_GLOBAL_EN    7
`define BIT_GROUP_EN     6
`define BIT_ST_REQ_RISE  0
`define BIT_ST_STALE     1
`define BIT_ST_BUS_ERR   2

// reset values
`define RESET_BYTE       8'h00
`define RESET_WORD       32'h0000_0000

`endif

// ---- src/irq_bank_pkg.sv ----
package irq_bank_pkg;

	// one-cycle condition pulses from the peripherals
	typedef struct packed {
		logic adc_done;
		logic sync_port_xfer_done;
		logic sync_port_seq_done;
		logic capcmp_one_hit;
		logic timer_two_match;
		logic timer_one_ovf;
	} periph_events_s;

	// buffer levels that the serial unit drives
	typedef struct packed {
		logic rx_buffer_full;
		logic tx_buffer_empty;
	} uart_levels_s;

	// decoded register write
	typedef struct packed {
		logic       we;
		logic [7:0] data;
	} reg_write_s;

	typedef enum logic {
		ph_idle,
		ph_answer
	} apb_phase_e;

endpackage

// ---- src/request_flag_bank.sv ----
`include "irq_bank_params.svh"

module request_flag_bank (
	// clock and reset
	input  wire logic                      clk,
	input  wire logic                      rst,
	// software write
	input  wire irq_bank_pkg::reg_write_s  sw_write,
	// hardware sets and levels
	input  wire logic [7:0]                set_event,
	input  wire logic [7:0]                level_in,
	// flags
	output logic [7:0]                     flags
);

	localparam logic [7:0] RW_MASK    = `REQUEST_1_RW;
	localparam logic [7:0] LEVEL_MASK = `REQUEST_1_LEVEL;

	genvar i;
	generate
		for (i = 0; i < 8; i++) begin : g_flag
			if (LEVEL_MASK[i]) begin : g_level
				// mirrors buffer state; software cannot write it
				always_ff @(posedge clk or posedge rst) begin
					if (rst)
						flags[i] <= 1'b0;
					else
						flags[i] <= level_in[i];
				end
			end else if (RW_MASK[i]) begin : g_sticky
				// set beats a same-cycle software clear
				always_ff @(posedge clk or posedge rst) begin
					if (rst)
						flags[i] <= 1'b0;
					else if (set_event[i])
						flags[i] <= 1'b1;
					else if (sw_write.we)
						flags[i] <= sw_write.data[i];
				end
			end else begin : g_unused
				assign flags[i] = 1'b0;
			end
		end
	endgenerate

endmodule

// ---- src/irq_status_unit.sv ----
`include "irq_bank_params.svh"

module irq_status_unit (
	// clock and reset
	input  wire logic                      clk,
	input  wire logic                      rst,
	// software access
	input  wire irq_bank_pkg::reg_write_s  status_write,
	input  wire irq_bank_pkg::reg_write_s  mask_write,
	// events
	input  wire logic [7:0]                events,
	// state
	output logic [7:0]                     status,
	output logic [7:0]                     mask,
	output logic                           irq
);

	localparam logic [7:0] IMPL = `IRQ_STATUS_MASK;

	logic [7:0] status_next;
	logic [7:0] w1c;

	assign w1c         = status_write.we ? status_write.data : `RESET_BYTE;
	// a fresh event survives a write-one-to-clear in the same cycle
	assign status_next = ((status & ~w1c) | events) & IMPL;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			status <= `RESET_BYTE;
			mask   <= `RESET_BYTE;
			irq    <= 1'b0;
		end else begin
			status <= status_next;
			if (mask_write.we)
				mask <= mask_write.data & IMPL;
			irq    <= |(status & mask);
		end
	end

endmodule

// ---- src/periph_irq_bank.sv ----

`include "irq_bank_params.svh"

module periph_irq_bank (
	// clock and reset
	input  wire logic                          clk,
	input  wire logic                          rst,
	// apb slave
	input  wire logic                          psel,
	input  wire logic                          penable,
	input  wire logic                          pwrite,
	input  wire logic [7:0]                    paddr,
	input  wire logic [31:0]                   pwdata,
	output logic                               pready,
	output logic [31:0]                        prdata,
	output logic                               pslverr,
	// peripheral conditions
	input  wire irq_bank_pkg::periph_events_s  periph_events,
	input  wire irq_bank_pkg::uart_levels_s    uart_levels,
	input  wire logic [7:0]                    request_2_flags,
	// requests
	output logic                               core_irq_req,
	output logic                               irq
);

	// apb phase tracking
	irq_bank_pkg::apb_phase_e phase_reg;
	irq_bank_pkg::apb_phase_e phase_next;
	logic                     pready_reg;
	logic [31:0]              prdata_reg;
	logic                     pslverr_reg;
	logic [31:0]              read_word;

	// software-visible state
	logic [7:0] peripheral_irq_enable_1_reg;
	logic [7:0] peripheral_irq_enable_2_reg;
	logic [7:0] core_irq_control_reg;
	logic [7:0] peripheral_irq_request_1;
	logic [7:0] irq_status;
	logic [7:0] irq_mask;

	// request path
	logic       core_irq_req_reg;
	logic       core_irq_req_next;

	// bus decode
	logic       access_start;
	logic       write_commit;
	logic       hit_enable_1;
	logic       hit_enable_2;
	logic       hit_request_1;
	logic       hit_core_ctrl;
	logic       hit_status;
	logic       hit_mask;
	logic       hit_pending;
	logic       addr_mapped;
	logic [7:0] wbyte;
	logic [7:0] read_byte;
	logic [7:0] read_lo;
	logic [7:0] read_hi;
	logic       bad_access;
	logic       we_enable_1;
	logic       we_enable_2;
	logic       we_core_ctrl;
	logic [7:0] rd_enable_1;
	logic [7:0] rd_enable_2;
	logic [7:0] rd_request_1;
	logic [7:0] rd_core_ctrl;
	logic [7:0] rd_status;
	logic [7:0] rd_mask;

	// flag inputs and combination
	logic [7:0] req1_set;
	logic [7:0] req1_level;
	logic [7:0] req2_impl;
	logic [7:0] pending_1;
	logic [7:0] pending_2;
	logic       any_pending;
	logic       global_en;
	logic       group_en;
	logic [7:0] stale_bits;
	logic       stale_event;
	logic [7:0] status_events;

	irq_bank_pkg::reg_write_s req1_write;
	irq_bank_pkg::reg_write_s status_write;
	irq_bank_pkg::reg_write_s mask_write;

	// apb decode: one wait state, answer on the second access cycle
	assign access_start  = psel & penable & (phase_reg == irq_bank_pkg::ph_idle);
	assign write_commit  = psel & penable & pready_reg & pwrite;
	assign wbyte         = pwdata[7:0];

	assign hit_enable_1  = (paddr == `OFF_ENABLE_1);
	assign hit_enable_2  = (paddr == `OFF_ENABLE_2);
	assign hit_request_1 = (paddr == `OFF_REQUEST_1);
	assign hit_core_ctrl = (paddr == `OFF_CORE_CTRL);
	assign hit_status    = (paddr == `OFF_IRQ_STATUS);
	assign hit_mask      = (paddr == `OFF_IRQ_MASK);
	assign hit_pending   = (paddr == `OFF_PENDING);
	assign addr_mapped   = hit_enable_1 | hit_enable_2 | hit_request_1 | hit_core_ctrl
		| hit_status | hit_mask | hit_pending;
	// refused accesses answer with an error and change nothing but the bus error status bit
	assign bad_access    = access_start & ~addr_mapped;

	assign we_enable_1        = write_commit & hit_enable_1;
	assign we_enable_2        = write_commit & hit_enable_2;
	assign we_core_ctrl       = write_commit & hit_core_ctrl;
	assign req1_write.we      = write_commit & hit_request_1;
	assign req1_write.data    = wbyte;
	assign status_write.we    = write_commit & hit_status;
	assign status_write.data  = wbyte;
	assign mask_write.we      = write_commit & hit_mask;
	assign mask_write.data    = wbyte;

	// read selection; unused upper bits read zero
	assign rd_enable_1  = hit_enable_1  ? peripheral_irq_enable_1_reg : `RESET_BYTE;
	assign rd_enable_2  = hit_enable_2  ? peripheral_irq_enable_2_reg : `RESET_BYTE;
	assign rd_request_1 = hit_request_1 ? peripheral_irq_request_1    : `RESET_BYTE;
	assign rd_core_ctrl = hit_core_ctrl ? core_irq_control_reg        : `RESET_BYTE;
	assign rd_status    = hit_status    ? irq_status                  : `RESET_BYTE;
	assign rd_mask      = hit_mask      ? irq_mask                    : `RESET_BYTE;
	// the hits are one-hot, so an or of the views is the selected byte
	assign read_byte    = rd_enable_1 | rd_enable_2 | rd_request_1 | rd_core_ctrl
		| rd_status | rd_mask;
	assign read_lo      = hit_pending ? pending_1 : read_byte;
	assign read_hi      = hit_pending ? pending_2 : `RESET_BYTE;
	// a write answers with zero data rather than a register image
	assign read_word    = pwrite ? `RESET_WORD : {16'h0000, read_hi, read_lo};

	always_comb begin
		phase_next = phase_reg;
		case (phase_reg)
			irq_bank_pkg::ph_idle: begin
				if (access_start)
					phase_next = irq_bank_pkg::ph_answer;
			end
			irq_bank_pkg::ph_answer: begin
				phase_next = irq_bank_pkg::ph_idle;
			end
			default: begin
				phase_next = irq_bank_pkg::ph_idle;
			end
		endcase
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			phase_reg <= irq_bank_pkg::ph_idle;
		else
			phase_reg <= phase_next;
	end

	// ready stands one cycle, the second access cycle
	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			pready_reg <= 1'b0;
		else
			pready_reg <= access_start;
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			pslverr_reg <= 1'b0;
		else
			pslverr_reg <= bad_access;
	end

	// read data held until the next access starts
	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			prdata_reg <= `RESET_WORD;
		else if (access_start)
			prdata_reg <= read_word;
	end

	assign pready  = pready_reg;
	assign prdata  = prdata_reg;
	assign pslverr = pslverr_reg;

	// enable and control registers; unimplemented bits masked off
	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			peripheral_irq_enable_1_reg <= `RESET_BYTE;
		else if (we_enable_1)
			peripheral_irq_enable_1_reg <= wbyte & `ENABLE_1_MASK;
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			peripheral_irq_enable_2_reg <= `RESET_BYTE;
		else if (we_enable_2)
			peripheral_irq_enable_2_reg <= wbyte & `ENABLE_2_MASK;
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			core_irq_control_reg <= `RESET_BYTE;
		else if (we_core_ctrl)
			core_irq_control_reg <= wbyte & `CORE_CTRL_MASK;
	end

	// hardware set sources of request register 1
	always_comb begin
		req1_set                  = `RESET_BYTE;
		req1_set[`BIT_ADC]        = periph_events.adc_done;
		req1_set[`BIT_SYNC_PORT]  = periph_events.sync_port_xfer_done
			| periph_events.sync_port_seq_done;
		req1_set[`BIT_CAPCMP_ONE] = periph_events.capcmp_one_hit;
		req1_set[`BIT_TIMER_TWO]  = periph_events.timer_two_match;
		req1_set[`BIT_TIMER_ONE]  = periph_events.timer_one_ovf;
	end

	always_comb begin
		req1_level                = `RESET_BYTE;
		req1_level[`BIT_UART_RX]  = uart_levels.rx_buffer_full;
		req1_level[`BIT_UART_TX]  = uart_levels.tx_buffer_empty;
	end

	request_flag_bank u_request_1 (
		.clk       (clk),
		.rst       (rst),
		.sw_write  (req1_write),
		.set_event (req1_set),
		.level_in  (req1_level),
		.flags     (peripheral_irq_request_1)
	);

	// combine flags with enables
	assign req2_impl   = request_2_flags & `REQUEST_2_MASK;
	assign pending_1   = peripheral_irq_request_1 & peripheral_irq_enable_1_reg;
	assign pending_2   = req2_impl & peripheral_irq_enable_2_reg;
	assign any_pending = |{pending_1, pending_2};
	assign global_en   = core_irq_control_reg[`BIT_GLOBAL_EN];
	assign group_en    = core_irq_control_reg[`BIT_GROUP_EN];

	// global or group enable low blocks core_irq_req, whatever the enables hold; irq is not gated
	assign core_irq_req_next = global_en & group_en & any_pending;

	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			core_irq_req_reg <= 1'b0;
		else
			core_irq_req_reg <= core_irq_req_next;
	end

	assign core_irq_req = core_irq_req_reg;

	// a request 1 enable written while its flag is already up fires at once;
	// flag it so software can spot a missed pre-clear
	assign stale_bits  = (wbyte & ~peripheral_irq_enable_1_reg & peripheral_irq_request_1);
	assign stale_event = we_enable_1 & (|stale_bits);

	always_comb begin
		status_events                   = `RESET_BYTE;
		status_events[`BIT_ST_REQ_RISE] = core_irq_req_next & ~core_irq_req_reg;
		status_events[`BIT_ST_STALE]    = stale_event;
		status_events[`BIT_ST_BUS_ERR]  = bad_access;
	end

	irq_status_unit u_status (
		.clk          (clk),
		.rst          (rst),
		.status_write (status_write),
		.mask_write   (mask_write),
		.events       (status_events),
		.status       (irq_status),
		.mask         (irq_mask),
		.irq          (irq)
	);

endmodule

// ---- test/periph_irq_bank_assertions.sv ----
module periph_irq_bank_assertions (
	// clock and reset
	input wire logic        clk,
	input wire logic        rst,
	// apb
	input wire logic        psel,
	input wire logic        penable,
	input wire logic [7:0]  paddr,
	input wire logic        pready,
	input wire logic [31:0] prdata,
	input wire logic        pslverr,
	// requests
	input wire logic        core_irq_req,
	input wire logic        irq
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clk); endclocking
	default disable iff (rst);

	sequence setup_s;
		psel && !penable;
	endsequence
	sequence access_s;
		psel && penable && !pready;
	endsequence

	access_answer_a: assert property (setup_s ##1 access_s |=> pready)
		else $error("no answer one cycle after access");
	ready_pulse_a: assert property (pready |=> !pready)
		else $error("ready held longer than one cycle");
	ready_in_xfer_a: assert property (pready |-> psel && penable)
		else $error("ready outside a transfer");
	err_with_ready_a: assert property (pslverr |-> pready)
		else $error("error without ready");
	upper_zero_a: assert property (pready |-> prdata[31:16] == 16'h0000)
		else $error("upper read bits not zero");
	unmapped_err_a: assert property (pready && paddr > 8'h18 |-> pslverr)
		else $error("unmapped access not refused");
	mapped_ok_a: assert property (pready && paddr <= 8'h18 && paddr[1:0] == 2'h0
		|-> !pslverr)
		else $error("mapped access refused");
	reset_quiet_a: assert property (disable iff (1'b0) rst
		|-> !core_irq_req && !irq && !pready)
		else $error("outputs active in reset");
endmodule

// ---- test/periph_model.sv ----
module periph_model (
	// clock and reset
	input wire logic                clk,
	input wire logic                rst,
	// bench commands
	input wire logic [5:0]          fire,
	input wire logic                rx_arrive,
	input wire logic                rx_take,
	input wire logic                tx_fill,
	input wire logic [7:0]          r2_level,
	// toward the bank
	output irq_bank_pkg::periph_events_s ev,
	output irq_bank_pkg::uart_levels_s   uart,
	output logic [7:0]              r2
);
	timeunit 1ns;
	timeprecision 1ps;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ev <= '0;
			uart <= '0;
			r2 <= '0;
		end else begin
			ev <= fire;
			if (rx_take)
				uart.rx_buffer_full <= 1'b0;
			else if (rx_arrive)
				uart.rx_buffer_full <= 1'b1;
			uart.tx_buffer_empty <= !tx_fill;
			r2 <= r2_level;
		end
	end
endmodule

// ---- test/tb_periph_irq_bank.sv ----
module tb_periph_irq_bank;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk, rst, psel, penable, pwrite, pready, pslverr, er, core_irq_req, irq;
	logic        rx_arrive, rx_take, tx_fill;
	logic [7:0]  paddr, r2_level, r2;
	logic [5:0]  fire;
	logic [31:0] pwdata, prdata, rd;
	logic [7:0]  fmask [0:5] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h08, 8'h40};
	irq_bank_pkg::periph_events_s ev;
	irq_bank_pkg::uart_levels_s   uart;
	int          err_count = 0;
	int          total_checks = 0;

	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	periph_irq_bank DUT (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
		.prdata(prdata), .pslverr(pslverr), .periph_events(ev), .uart_levels(uart),
		.request_2_flags(r2), .core_irq_req(core_irq_req), .irq(irq));
	periph_model model (.clk(clk), .rst(rst), .fire(fire), .rx_arrive(rx_arrive),
		.rx_take(rx_take), .tx_fill(tx_fill), .r2_level(r2_level), .ev(ev),
		.uart(uart), .r2(r2));

	task summarize;
		$display("checks %0d mismatches %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			err_count++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// holds the request until ready is seen at an edge
	task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1) begin
			err_count++;
			$display("Error at %0t: ready timeout got %h expected %h", $time, pready, 1'b1);
			summarize();
		end else begin
			rd = prdata;
			er = pslverr;
			psel <= 1'b0;
			penable <= 1'b0;
		end
	endtask

	task wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask

	task rdc(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(rd, exp);
	endtask

	task settle;
		repeat (3) @(posedge clk);
	endtask

	task pulse(input logic [5:0] f);
		@(posedge clk);
		fire <= f;
		@(posedge clk);
		fire <= 6'h00;
	endtask

	initial begin
		rst = 1'b1;
		{psel, penable, pwrite, rx_arrive, rx_take} = '0;
		tx_fill = 1'b1;
		paddr = 8'h00;
		pwdata = 32'h0;
		fire = 6'h00;
		r2_level = 8'h00;
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		for (int i = 0; i < 7; i++) rdc(8'(i * 4), 32'h0);
		$display("test reset done");
		wr(8'h00, 32'hFF);
		rdc(8'h00, 32'h7F);
		wr(8'h04, 32'hFF);
		rdc(8'h04, 32'hFD);
		wr(8'h08, 32'hFF);
		rdc(8'h08, 32'h4F);
		wr(8'h18, 32'h0);
		rdc(8'h18, 32'h4F);
		for (int i = 0; i < 3; i++) wr(8'(i * 4), 32'h0);
		$display("test layout done");
		for (int i = 0; i < 6; i++) begin
			pulse(6'(1 << i));
			settle();
			rdc(8'h08, 32'(fmask[i]));
			wr(8'h08, 32'h0);
			rdc(8'h08, 32'h0);
		end
		$display("test events done");
		pulse(6'h01);
		wr(8'h00, 32'h01);
		for (int c = 0; c < 4; c++) begin
			wr(8'h0C, 32'(c << 6));
			settle();
			chk(32'(core_irq_req), 32'(c == 3));
		end
		wr(8'h00, 32'h0);
		settle();
		chk(32'(core_irq_req), 32'h0);
		r2_level <= 8'hFF;
		wr(8'h04, 32'hFF);
		rdc(8'h18, 32'hFD00);
		r2_level <= 8'h02;
		settle();
		chk(32'(core_irq_req), 32'h0);
		$display("test gating done");
		wr(8'h14, 32'h07);
		rdc(8'h10, 32'h03);
		settle();
		chk(32'(irq), 32'h1);
		apb(1'b0, 8'h1C, 32'h0);
		chk(32'(er), 32'h1);
		rdc(8'h10, 32'h07);
		wr(8'h14, 32'h0);
		settle();
		chk(32'(irq), 32'h0);
		wr(8'h10, 32'h07);
		rdc(8'h10, 32'h0);
		$display("test status done");
		wr(8'h08, 32'h0);
		rx_arrive <= 1'b1;
		settle();
		rx_arrive <= 1'b0;
		wr(8'h08, 32'h0);
		rdc(8'h08, 32'h20);
		rx_take <= 1'b1;
		settle();
		rx_take <= 1'b0;
		rdc(8'h08, 32'h0);
		tx_fill <= 1'b0;
		settle();
		rdc(8'h08, 32'h10);
		tx_fill <= 1'b1;
		settle();
		rdc(8'h08, 32'h0);
		$display("test serial done");
		summarize();
	end
endmodule

bind periph_irq_bank periph_irq_bank_assertions chk_u (.clk(clk), .rst(rst),
	.psel(psel), .penable(penable), .paddr(paddr), .pready(pready), .prdata(prdata),
	.pslverr(pslverr), .core_irq_req(core_irq_req), .irq(irq));
